// ### core/psp_serial_port.sv
// Serial slave port of a digital potentiometer with wiper, control and fuse store.
// Assumes the host acts as master; pins are sampled by the 100 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module psp_serial_port #(
   parameter int STORE_CYC = psp_pkg::STORE_CYCLES
) (
   // System
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // Serial pins
   input wire logic i_sync_n,
   input wire logic i_sclk,
   input wire logic i_din,
   // Open-drain outputs: serial value is always low, ready value is the inverse of its enable; enable pulls
   output logic o_serial_out,
   output logic o_serial_out_oe,
   output logic o_ready,
   output logic o_ready_oe,
   // Device state
   output logic [9:0] o_wiper,
   output logic [3:0] o_ctrl,
   output logic o_shutdown
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [2:0] sync_sr_reg; // Frame sync stages
   logic [2:0] sclk_sr_reg; // Serial clock stages
   logic [2:0] din_sr_reg;  // Data stages
   logic sync_lvl_reg; // Accepted frame sync level
   logic sclk_lvl_reg; // Accepted serial clock level
   // Three stages per pin; only the last two are compared
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         sync_sr_reg <= 3'h7;
         // Idle level of the serial clock, so no false fall after reset
         sclk_sr_reg <= 3'h7;
         din_sr_reg <= 3'h0;
      end else begin
         sync_sr_reg <= {sync_sr_reg[1:0], i_sync_n};
         sclk_sr_reg <= {sclk_sr_reg[1:0], i_sclk};
         din_sr_reg <= {din_sr_reg[1:0], i_din};
      end
   end
   logic sync_low; // Frame active
   logic sclk_fall; // Serial clock falling edge
   logic sync_rise; // Frame end
   // A new pin level counts only once the second and third stages agree
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         sync_lvl_reg <= 1'b1;
         sclk_lvl_reg <= 1'b1;
      end else begin
         // Frame sync level
         if (sync_sr_reg[2] == sync_sr_reg[1]) begin
            sync_lvl_reg <= sync_sr_reg[2];
         end
         // Serial clock level
         if (sclk_sr_reg[2] == sclk_sr_reg[1]) begin
            sclk_lvl_reg <= sclk_sr_reg[2];
         end
      end
   end
   assign sync_low = ~sync_lvl_reg;
   // Edges last one cycle: the accepted level follows on the next edge
   assign sclk_fall = sclk_lvl_reg & ~sclk_sr_reg[2] & ~sclk_sr_reg[1];
   assign sync_rise = ~sync_lvl_reg & sync_sr_reg[2] & sync_sr_reg[1];

   // ----------------------------------------
   // Shift register and bit count
   // ----------------------------------------
   logic [15:0] shift_reg; // Input word
   logic [15:0] out_reg;   // Word shifted out
   logic [3:0] bit_cnt_reg; // Bit position within a word
   logic full_reg; // A whole multiple of 16 bits seen
   logic busy_reg; // Store in progress
   logic [3:0] cmd; // Received command
   assign cmd = shift_reg[psp_pkg::CMD_MSB:psp_pkg::CMD_LSB];
   // shift on falling edges in frame
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         shift_reg <= 16'h0000;
         bit_cnt_reg <= 4'h0;
         full_reg <= 1'b0;
      end else if (!sync_low) begin
         // Idle: restart the count for the next frame
         bit_cnt_reg <= 4'h0;
         full_reg <= 1'b0;
      end else if (sclk_fall && !busy_reg) begin
         shift_reg <= {shift_reg[14:0], din_sr_reg[2]};
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         // word complete only on every 16th bit
         full_reg <= (bit_cnt_reg == psp_pkg::BIT_LAST);
      end
   end

   // ----------------------------------------
   // Readback and daisy-chain output
   // ----------------------------------------
   logic [15:0] rd_word_reg; // Value queued for next frame
   logic [4:0] fuse_reg;     // Fuse memory value
   logic [9:0] wiper_reg;    // Wiper register
   logic commit;             // Valid word at sync rise
   logic load_reg;           // Answer ready to load, one cycle after commit
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         out_reg <= 16'h0000;
         load_reg <= 1'b0;
         o_serial_out_oe <= 1'b0;
         o_serial_out <= 1'b0;
      end else begin
         // Wait a cycle so the answer queued by this frame is the one loaded
         load_reg <= commit;
         if (load_reg) begin
            out_reg <= rd_word_reg;
         end else if (sync_low && sclk_fall && !busy_reg) begin
            out_reg <= {out_reg[14:0], din_sr_reg[2]};
         end
         // Pull low only for a zero bit during a frame
         o_serial_out_oe <= sync_low & ~out_reg[15];
         // Open-drain value: the pin only ever pulls low
         o_serial_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // Command decode at frame end
   // ----------------------------------------
   assign commit = sync_rise & full_reg & ~busy_reg;
   logic store_go; // Start a store
   assign store_go = commit && (cmd == psp_pkg::CMD_STORE);
   // decode and update on valid frame
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         wiper_reg <= psp_pkg::WIPER_MID;
         o_ctrl <= psp_pkg::CTRL_RST;
         o_shutdown <= 1'b0;
         rd_word_reg <= 16'h0000;
      end else if (commit) begin
         rd_word_reg <= 16'h0000;
         case (cmd)
            psp_pkg::CMD_WR_WIPER: wiper_reg <= shift_reg[psp_pkg::DATA_MSB:0];
            psp_pkg::CMD_RD_WIPER: rd_word_reg <= {6'h00, wiper_reg};
            psp_pkg::CMD_REFRESH: wiper_reg <= {fuse_reg, 5'h00};
            psp_pkg::CMD_RD_FUSE: rd_word_reg <= {11'h000, fuse_reg};
            psp_pkg::CMD_WR_CTRL: o_ctrl <= shift_reg[psp_pkg::CTRL_MSB:0];
            psp_pkg::CMD_RD_CTRL: rd_word_reg <= {12'h000, o_ctrl};
            psp_pkg::CMD_SHUTDOWN: o_shutdown <= shift_reg[0];
            default: begin
               // No-op, store and unknown codes only clear the queued answer here
            end
         endcase
      end
   end
   always_ff @(posedge i_clk_sys) begin
      o_wiper <= wiper_reg;
   end

   // ----------------------------------------
   // Fuse store timer and ready flag
   // ----------------------------------------
   logic [31:0] store_cnt_reg; // Cycles left in store
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         busy_reg <= 1'b0;
         store_cnt_reg <= 32'h0;
         fuse_reg <= 5'h00;
      end else if (store_go) begin
         busy_reg <= 1'b1;
         store_cnt_reg <= 32'(STORE_CYC - 1);
         fuse_reg <= wiper_reg[psp_pkg::DATA_MSB -: (psp_pkg::FUSE_MSB + 1)];
      end else if (busy_reg) begin
         if (store_cnt_reg == 32'h0) begin
            busy_reg <= 1'b0;
         end else begin
            store_cnt_reg <= store_cnt_reg - 32'h1;
         end
      end
   end
   logic busy_next; // Busy state after this edge
   assign busy_next = store_go | (busy_reg & (store_cnt_reg != 32'h0));
   // ready follows the next busy state, low exactly while storing
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_ready <= 1'b1;
         o_ready_oe <= 1'b0;
      end else begin
         o_ready <= ~busy_next;
         // Open-drain enable pulls the ready line low while busy
         o_ready_oe <= busy_next;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // short frame leaves wiper alone
   a_short_abort: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (sync_rise && !full_reg) |=> $stable(wiper_reg)) else $error("short frame changed wiper");
   a_wiper_write: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (commit && cmd == psp_pkg::CMD_WR_WIPER) |=> (wiper_reg == $past(shift_reg[psp_pkg::DATA_MSB:0])))
      else $error("wiper not written");
   a_store_lock: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      busy_reg |=> (!$past(busy_reg) || $stable(shift_reg))) else $error("shift moved during store");
   a_ready_busy: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      busy_reg |-> !o_ready) else $error("ready high while storing");
   a_idle_ignore: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (!sync_low && !$past(sync_low)) |=> $stable(shift_reg)) else $error("shift moved while idle");
   a_bit_count: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (sync_low && sclk_fall && !busy_reg) |=> (bit_cnt_reg == $past(bit_cnt_reg) + 4'h1)) else $error("bit count");
   a_out_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !sync_low |=> !o_serial_out_oe) else $error("serial out driven idle");
   a_shutdown: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (commit && cmd == psp_pkg::CMD_SHUTDOWN) |=> (o_shutdown == $past(shift_reg[0]))) else $error("shutdown");
   c_write: cover property (@(posedge i_clk_sys) commit && cmd == psp_pkg::CMD_WR_WIPER);
   c_abort: cover property (@(posedge i_clk_sys) sync_rise && !full_reg);
   c_store: cover property (@(posedge i_clk_sys) store_go);
   c_readback: cover property (@(posedge i_clk_sys) load_reg && (rd_word_reg != 16'h0000));
   // ready pin enable is the inverse of the ready level
   a_ready_pair: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_ready_oe == !o_ready) else $error("ready enable mismatch");
endmodule
`default_nettype wire

// ### pkg/psp_pkg.sv
// Constants, commands and timing for the potentiometer serial port.
// Assumes a 100 MHz system clock; serial pins arrive asynchronously.
package psp_pkg;
   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam int WORD_BITS = 16;
   localparam int CMD_MSB = 13;
   localparam int CMD_LSB = 10;
   localparam int DATA_MSB = 9;
   localparam int CTRL_MSB = 3;
   localparam int FUSE_MSB = 4;
   localparam logic [3:0] BIT_LAST = 4'hF;
   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WR_WIPER = 4'h1;
   localparam logic [3:0] CMD_RD_WIPER = 4'h2;
   localparam logic [3:0] CMD_STORE = 4'h3;
   localparam logic [3:0] CMD_REFRESH = 4'h4;
   localparam logic [3:0] CMD_RD_FUSE = 4'h5;
   localparam logic [3:0] CMD_WR_CTRL = 4'h6;
   localparam logic [3:0] CMD_RD_CTRL = 4'h7;
   localparam logic [3:0] CMD_SHUTDOWN = 4'h8;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [9:0] WIPER_MID = 10'h200;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam int CLK_MHZ = 100;
   localparam int STORE_TIME_MS = 6;
   localparam int STORE_CYCLES = STORE_TIME_MS * 1000 * CLK_MHZ;
endpackage

// ### testbench/psp_host_model.sv
// Host model: drives frame sync, serial clock and data toward the port.
// Assumes a pull-up on the serial output line, so its level is ~oe.
`timescale 1ns/1ps
`default_nettype none
module psp_host_model (
   // Serial pins toward the device
   output logic o_sync_n,
   output logic o_sclk,
   output logic o_din,
   // Open-drain enable of the serial output
   input wire logic i_out_oe
);
   logic [15:0] rd_word; // Line bits seen in the last frame
   // Idle: sync high, clock parked high
   initial begin
      o_sync_n = 1'b1;
      o_sclk = 1'b1;
      o_din = 1'b0;
      rd_word = 16'h0000;
   end
   task automatic frame(input logic [31:0] w, input int n);
      o_sync_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         o_din = w[i];
         #62.5 rd_word = {rd_word[14:0], ~i_out_oe};
         o_sclk = 1'b0;
         #62.5 o_sclk = 1'b1;
      end
      #62.5 o_sync_n = 1'b1;
      // Released data shows the inverse of the last bit
      o_din = ~o_din;
      #100;
   endtask
   // clock and data noise outside frames
   task automatic noise();
      repeat (16) begin
         #62.5 o_sclk = ~o_sclk;
         o_din = ~o_din;
      end
   endtask
endmodule
`default_nettype wire

// ### testbench/potentiometer_serial_port_bench.sv
// Self-checking bench for the potentiometer serial port.
// Assumes a shortened store time and the host model in its own file.
`timescale 1ns/1ps
`default_nettype none
module potentiometer_serial_port_bench;
   localparam int STC = 400; // Store cycles for simulation
   logic clk = 1'b0, rstn = 1'b0, sync_n, sclk, din, so, so_oe, rdy, rdy_oe, shd;
   logic [9:0] wiper;
   logic [3:0] ctrl;
   int num_errors = 0, samples_checked = 0;
   int low_cycles = 0; // Cycles with ready low
   always #5 clk = ~clk;
   // Ready changes on rising edges, so count it where it is settled
   always @(negedge clk) if (rstn && rdy === 1'b0) low_cycles++;
   psp_serial_port #(.STORE_CYC(STC)) DUT (.i_clk_sys(clk), .i_rstn(rstn), .i_sync_n(sync_n),
      .i_sclk(sclk), .i_din(din), .o_serial_out(so), .o_serial_out_oe(so_oe), .o_ready(rdy),
      .o_ready_oe(rdy_oe), .o_wiper(wiper), .o_ctrl(ctrl), .o_shutdown(shd));
   psp_host_model host (.o_sync_n(sync_n), .o_sclk(sclk), .o_din(din), .i_out_oe(so_oe));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] wd(input logic [3:0] c, input logic [9:0] d);
      return {2'b00, c, d};
   endfunction
   task automatic stop_test();
      $display("Checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Frame then settle: update lands within 6 clocks of sync rise
   task automatic send(input logic [31:0] w, input int n);
      host.frame(w, n);
      repeat (8) @(negedge clk);
   endtask
   task automatic wait_rdy(input logic v);
      int c;
      for (c = 0; c < 1000 && rdy !== v; c++) @(negedge clk);
      if (c == 1000) begin
         num_errors++;
         stop_test();
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [15:0] r;
      logic [9:0] w;
      r = 16'h003D;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      chk("wiper", 16'(wiper), 16'h0200);
      chk("ready", 16'(rdy), 16'h0001);
      // Random and corner wiper writes with readback
      for (int k = 0; k < 6; k++) begin
         r = nxt(r);
         w = (k == 0) ? 10'h3FF : r[9:0];
         send(wd(psp_pkg::CMD_WR_WIPER, w), 16);
         chk("wiper", 16'(wiper), 16'(w));
         send(wd(psp_pkg::CMD_RD_WIPER, r[15:6]), 16);
         send(wd(psp_pkg::CMD_NOP, 10'h155), 16);
         chk("readback", host.rd_word, 16'(w));
         chk("serial out value", 16'(so), 16'h0000);
         chk("nop", 16'(wiper), 16'(w));
      end
      send(wd(psp_pkg::CMD_WR_WIPER, ~w), 8);
      chk("abort", 16'(wiper), 16'(w));
      send({8'h00, wd(psp_pkg::CMD_WR_WIPER, 10'h2CC)}, 24);
      chk("odd frame", 16'(wiper), 16'(w));
      host.noise();
      chk("idle noise", 16'(wiper), 16'(w));
      send({wd(psp_pkg::CMD_WR_WIPER, 10'h111), wd(psp_pkg::CMD_WR_WIPER, 10'h0AA)}, 32);
      chk("long frame", 16'(wiper), 16'h00AA);
      // Control write and read
      send(wd(psp_pkg::CMD_WR_CTRL, {6'h00, r[3:0]}), 16);
      chk("ctrl", 16'(ctrl), 16'(r[3:0]));
      send(wd(psp_pkg::CMD_RD_CTRL, 10'h000), 16);
      send(wd(psp_pkg::CMD_NOP, 10'h000), 16);
      chk("ctrl read", host.rd_word, 16'(r[3:0]));
      for (int s = 1; s >= 0; s--) begin
         send(wd(psp_pkg::CMD_SHUTDOWN, 10'(s)), 16);
         chk("shutdown", 16'(shd), 16'(s));
      end
      // Store: ready low for the store time, shifts locked
      host.frame(wd(psp_pkg::CMD_STORE, 10'h000), 16);
      wait_rdy(1'b0);
      chk("ready oe", 16'(rdy_oe), 16'h0001);
      host.frame(wd(psp_pkg::CMD_WR_WIPER, 10'h001), 16);
      wait_rdy(1'b1);
      chk("store time", 16'(low_cycles), 16'(STC));
      chk("locked", 16'(wiper), 16'h00AA);
      send(wd(psp_pkg::CMD_WR_WIPER, 10'h3FF), 16);
      send(wd(psp_pkg::CMD_REFRESH, 10'h000), 16);
      chk("refresh", 16'(wiper), 16'h00A0);
      send(wd(psp_pkg::CMD_RD_FUSE, 10'h000), 16);
      send(wd(psp_pkg::CMD_NOP, 10'h000), 16);
      chk("fuse read", host.rd_word, 16'h0005);
      stop_test();
   end
endmodule
`default_nettype wire
